// ---- logic/dst_top.sv ----
// ============================================================
// dram/sdram timing and refresh control with avalon slave
module dst_top (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    // avalon-mm slave
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // memory side
    input wire logic I_SDRAM,        // memory type strap, 1 = sdram
    input wire logic I_AREA2,        // access targets area 2
    input wire logic I_EXTEND,       // extended timing from third bus control
    input wire logic I_DMA_SIDE,     // request comes from dma side controller
    input wire logic I_BUS_REQ,      // external bus cycle request
    input wire logic I_BUS_WRITE,    // that cycle is a write
    input wire logic I_BUS_END,      // current external cycle finishing
    input wire logic I_CMP_MATCH,    // compare match flag from refresh timer
    input wire logic I_SELF_EXIT,    // leave self-refresh
    output logic O_BUS_GRANT,        // bus cycle may start
    output logic O_REFRESH,          // refresh cycle running (RAS/auto)
    output logic O_SELF_REFRESH,     // memory held in self-refresh
    output logic O_REFRESH_ACK,      // one pulse: timer request consumed
    output logic O_BURST,
    output logic [3:0] O_ROW_BIT,
    output logic [3:0] O_RCD,
    output logic O_EDO_RISE,
    output logic [4:0] O_BUS_WIDTH
);
    import dst_pkg::*;
    // ============================================================
    // all state in one struct
    typedef struct packed {
        logic [15:0] mtc_q;        // main timing control
        logic [15:0] a2c_q;        // area-2 dram control
        logic [31:0] rdata_q;
        logic wait_q;              // waitrequest register
        logic ack_q;               // answer given, next cycle released
        dst_state_type st_q;
        logic pend_q;              // refresh request pending
        logic write_q;             // last cycle was a write
        logic grant_q;
        logic refresh_q;
        logic self_q;
        logic rack_q;
        logic burst_q;
        logic [3:0] row_q;
        logic [3:0] rcd_q;
        logic edo_q;
        logic [4:0] width_q;
    } dst_state_all_type;
    dst_state_all_type s_q;
    dst_state_all_type s_d;
    logic [15:0] sel_reg;          // register governing this access
    dst_timing_type tim;
    logic cnt_load;
    logic [3:0] cnt_value;
    logic cnt_done;
    logic rf_on;                   // refresh enabled
    logic rf_self;                 // self-refresh mode
    logic req;                     // avalon request present
    logic [15:0] wd;
    // ============================================================
    // area-2 dram uses its own register
    assign sel_reg = (I_AREA2 && !I_SDRAM) ? s_q.a2c_q : s_q.mtc_q;
    assign rf_on = sel_reg[DST_REFRESH_CONTROL_BIT_BIT];
    assign rf_self = sel_reg[DST_REFRESH_MODE_BIT_BIT];
    assign req = I_AVS_READ || I_AVS_WRITE;
    assign wd = I_AVS_WRITEDATA[15:0];
    dst_decode u_decode (
        .i_reg(sel_reg),
        .i_sdram(I_SDRAM),
        .i_area2(I_AREA2),
        .i_extend(I_EXTEND),
        .i_dma_side(I_DMA_SIDE),
        .o_timing(tim)
    );
    dst_cnt u_cnt (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_ce(I_CE),
        .i_load(cnt_load),
        .i_value(cnt_value),
        .o_done(cnt_done)
    );
    // ============================================================
    // next state: register bus, then sequencer
    always_comb begin
        s_d = s_q;
        cnt_load = 1'b0;
        cnt_value = 4'h0;
        s_d.rack_q = 1'b0;
        // bus: one wait cycle, then answer, then idle a cycle
        s_d.wait_q = 1'b1;
        s_d.ack_q = 1'b0;
        if (req && s_q.wait_q && !s_q.ack_q) begin
            s_d.wait_q = 1'b0;
            s_d.ack_q = 1'b1;
            s_d.rdata_q = 32'h0000_0000;
            unique case (I_AVS_ADDRESS)
                DST_ADDR_MTC: begin
                    s_d.rdata_q = {16'h0000, s_q.mtc_q};
                    if (I_AVS_WRITE) begin
                        // masked bits stay zero: bit 7 unwritable
                        if (I_AVS_BYTEENABLE[0]) begin
                            s_d.mtc_q[7:0] = wd[7:0] & DST_MTC_WMASK[7:0];
                        end
                        if (I_AVS_BYTEENABLE[1]) begin
                            s_d.mtc_q[15:8] = wd[15:8] & DST_MTC_WMASK[15:8];
                        end
                    end
                end
                DST_ADDR_A2C: begin
                    s_d.rdata_q = {16'h0000, s_q.a2c_q};
                    if (I_AVS_WRITE) begin
                        if (I_AVS_BYTEENABLE[0]) begin
                            s_d.a2c_q[7:0] = wd[7:0] & DST_A2C_WMASK[7:0];
                        end
                        if (I_AVS_BYTEENABLE[1]) begin
                            s_d.a2c_q[15:8] = wd[15:8] & DST_A2C_WMASK[15:8];
                        end
                    end
                end
                DST_ADDR_STS: begin
                    // read only status; writes ignored
                    s_d.rdata_q = {26'h0, s_q.pend_q, s_q.self_q, s_q.refresh_q,
                                   s_q.st_q};
                end
                default: begin
                    s_d.rdata_q = 32'h0000_0000; // unmapped reads zero
                end
            endcase
        end
        // latch timer request; ignored while self-refreshing
        if (I_CMP_MATCH && rf_on && !rf_self && s_q.st_q != DST_SELF) begin
            s_d.pend_q = 1'b1;
        end
        if (!rf_on) begin
            s_d.pend_q = 1'b0;
        end
        s_d.grant_q = 1'b0;
        unique case (s_q.st_q)
            DST_IDLE: begin
                // refresh preferred over a new cycle
                if (rf_on && rf_self) begin
                    s_d.st_q = DST_SELF;
                    s_d.self_q = 1'b1;
                    s_d.pend_q = 1'b0;
                end else if (s_q.pend_q || (I_CMP_MATCH && rf_on)) begin
                    s_d.st_q = DST_RAS;
                    s_d.refresh_q = 1'b1;
                    // a fresh match while an old one is served stays pending: set wins
                    s_d.pend_q = s_q.pend_q && I_CMP_MATCH;
                    s_d.rack_q = 1'b1;
                    cnt_load = 1'b1;
                    cnt_value = tim.refresh_ras_assert_time - 4'h1;
                end else if (I_BUS_REQ) begin
                    s_d.st_q = DST_BUSY;
                    s_d.grant_q = 1'b1;
                    s_d.write_q = I_BUS_WRITE;
                end
            end
            DST_BUSY: begin
                // running cycle always concludes first
                if (I_BUS_END) begin
                    s_d.st_q = DST_GAP;
                    cnt_load = 1'b1;
                    if (I_SDRAM && s_q.write_q) begin
                        cnt_value = tim.tpc + tim.write_to_precharge_delay - 4'h1;
                    end else begin
                        cnt_value = tim.tpc - 4'h1;
                    end
                end
            end
            DST_RAS: begin
                if (cnt_done) begin
                    s_d.st_q = DST_GAP;
                    s_d.refresh_q = 1'b0;
                    cnt_load = 1'b1;
                    cnt_value = tim.tpc - 4'h1;
                end
            end
            DST_GAP: begin
                // no new RAS / activate until gap elapses
                if (cnt_done) begin
                    s_d.st_q = DST_IDLE;
                end
            end
            DST_SELF: begin
                if (I_SELF_EXIT || !rf_on || !rf_self) begin
                    s_d.st_q = DST_GAP;
                    s_d.self_q = 1'b0;
                    cnt_load = 1'b1;
                    cnt_value = tim.tpc - 4'h1;
                end
            end
            default: begin
                s_d.st_q = DST_IDLE;
            end
        endcase
        // decoded timing registered for the memory side
        s_d.burst_q = tim.burst;
        s_d.row_q = tim.row_bit;
        s_d.rcd_q = tim.row_to_column_delay;
        s_d.edo_q = tim.edo_rise;
        s_d.width_q = (I_AREA2 && !I_SDRAM) ? DST_A2_WIDTH : 5'h00;
    end
    // ============================================================
    // synchronous reset whenever I_RESET is high, waitrequest set and the rest cleared; otherwise values advance while I_CE is high and are kept while it is low
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            s_q <= '0;
            s_q.mtc_q <= DST_MTC_RESET;
            s_q.a2c_q <= DST_A2C_RESET;
            s_q.wait_q <= 1'b1;
            s_q.st_q <= DST_IDLE;
        end else if (I_CE) begin
            s_q <= s_d;
        end
    end
    // ============================================================
    // outputs straight from flip-flops
    assign O_AVS_READDATA = s_q.rdata_q;
    assign O_AVS_WAITREQUEST = s_q.wait_q;
    assign O_BUS_GRANT = s_q.grant_q;
    assign O_REFRESH = s_q.refresh_q;
    assign O_SELF_REFRESH = s_q.self_q;
    assign O_REFRESH_ACK = s_q.rack_q;
    assign O_BURST = s_q.burst_q;
    assign O_ROW_BIT = s_q.row_q;
    assign O_RCD = s_q.rcd_q;
    assign O_EDO_RISE = s_q.edo_q;
    assign O_BUS_WIDTH = s_q.width_q;
endmodule : dst_top

// ---- logic/dst_pkg.sv ----
// ============================================================
// ============================================================
package dst_pkg;
    // ============================================================
    // register map
    localparam logic [3:0] DST_ADDR_MTC = 4'h0; // main timing control
    localparam logic [3:0] DST_ADDR_A2C = 4'h4; // area-2 dram control
    localparam logic [3:0] DST_ADDR_STS = 4'h8; // status readback
    localparam logic [15:0] DST_MTC_RESET = 16'h0000;
    localparam logic [15:0] DST_A2C_RESET = 16'h0000;
    // writable masks: bit 7 and bit 5 of main register stay zero
    localparam logic [15:0] DST_MTC_WMASK = 16'hFF5F;
    localparam logic [15:0] DST_A2C_WMASK = 16'hF35E;
    // ============================================================
    // field positions
    localparam int DST_TPC_LSB = 14;
    localparam int DST_RCD_LSB = 12;
    localparam int DST_WRITE_TO_PRECHARGE_DELAY_LSB = 10;
    localparam int DST_REFRESH_RAS_ASSERT_TIME_LSB = 8;
    localparam int DST_BE_BIT = 6;
    localparam int DST_AMX_LSB = 3;
    localparam int DST_REFRESH_CONTROL_BIT_BIT = 2;
    localparam int DST_REFRESH_MODE_BIT_BIT = 1;
    localparam int DST_EDO_BIT = 0;
    // ============================================================
    // timing: cycle figures offset from codes
    localparam logic [3:0] DST_ONE = 4'h1;      // code 00 -> 1 cycle
    localparam logic [3:0] DST_REFRESH_RAS_ASSERT_TIME_BASE = 4'h2; // code 00 -> 2 cycles
    localparam logic [1:0] DST_WRITE_TO_PRECHARGE_DELAY_RSVD = 2'h3;
    localparam logic [3:0] DST_ROW_BASE = 4'h9; // row starts at A9
    localparam logic [1:0] DST_AMX_SD_WRAP = 2'h3;
    localparam logic [4:0] DST_A2_WIDTH = 5'h10; // 16-bit area-2 bus
    // ============================================================
    // sequencer states
    typedef enum logic [2:0] {
        DST_IDLE = 3'b000,
        DST_BUSY = 3'b001,
        DST_RAS = 3'b010,
        DST_GAP = 3'b011,
        DST_SELF = 3'b100
    } dst_state_type;
    // decoded timing: tpc and delays for the counter, rcd, burst, row bit and edo for memory-side outputs
    typedef struct packed {
        logic [3:0] row_to_column_delay;      // row to column delay
        logic [3:0] tpc;      // precharge
        logic [3:0] write_to_precharge_delay;     // write to precharge
        logic [3:0] refresh_ras_assert_time;     // refresh RAS assert
        logic burst;
        logic [3:0] row_bit;  // address bit on A1
        logic edo_rise;
    } dst_timing_type;
endpackage : dst_pkg

// ---- logic/dst_cnt.sv ----
// ============================================================
// down counter used for every timed wait
module dst_cnt (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [3:0] i_value,
    output logic o_done
);
    typedef struct packed {
        logic [3:0] cnt_q;
    } dst_cnt_state_type;
    dst_cnt_state_type s_q;
    dst_cnt_state_type s_d;
    // ============================================================
    // next value: load wins, else count to zero
    always_comb begin
        s_d = s_q;
        if (i_load) begin
            s_d.cnt_q = i_value;
        end else if (s_q.cnt_q != 4'h0) begin
            s_d.cnt_q = s_q.cnt_q - 4'h1;
        end
    end
    // done ignores load: the sequencer loads on done, so feeding load back would form a loop
    assign o_done = (s_q.cnt_q == 4'h0);
    // ============================================================
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end
endmodule : dst_cnt

// ---- logic/dst_decode.sv ----
// ============================================================
// turns register codes into cycle counts
module dst_decode (
    input wire logic [15:0] i_reg,
    input wire logic i_sdram,
    input wire logic i_area2,
    input wire logic i_extend,
    input wire logic i_dma_side,
    output dst_pkg::dst_timing_type o_timing
);
    import dst_pkg::*;
    logic [1:0] address_multiplex_select;
    always_comb begin
        address_multiplex_select = i_reg[DST_AMX_LSB +: 2];
        o_timing = '0;
        o_timing.tpc = DST_ONE + {2'b00, i_reg[DST_TPC_LSB +: 2]};
        // extended timing: dma side keeps shortest delay here
        if (i_extend && i_dma_side) begin
            o_timing.row_to_column_delay = DST_ONE;
        end else begin
            o_timing.row_to_column_delay = DST_ONE + {2'b00, i_reg[DST_RCD_LSB +: 2]};
        end
        // reserved write code treated as longest legal
        if (i_reg[DST_WRITE_TO_PRECHARGE_DELAY_LSB +: 2] == DST_WRITE_TO_PRECHARGE_DELAY_RSVD) begin
            o_timing.write_to_precharge_delay = DST_ONE + {2'b00, DST_WRITE_TO_PRECHARGE_DELAY_RSVD} - 4'h1;
        end else begin
            o_timing.write_to_precharge_delay = DST_ONE + {2'b00, i_reg[DST_WRITE_TO_PRECHARGE_DELAY_LSB +: 2]};
        end
        o_timing.refresh_ras_assert_time = DST_REFRESH_RAS_ASSERT_TIME_BASE + {2'b00, i_reg[DST_REFRESH_RAS_ASSERT_TIME_LSB +: 2]};
        o_timing.burst = i_sdram || i_reg[DST_BE_BIT];
        // sdram code 11 wraps back to A9
        if (i_sdram && address_multiplex_select == DST_AMX_SD_WRAP) begin
            o_timing.row_bit = DST_ROW_BASE;
        end else begin
            o_timing.row_bit = DST_ROW_BASE + {2'b00, address_multiplex_select};
        end
        // edo only honoured for area-3 dram
        o_timing.edo_rise = i_reg[DST_EDO_BIT] && !i_sdram && !i_area2;
    end
endmodule : dst_decode

// ---- verif/dst_props.sv ----
// ============================================================
// port-level timing checks for the memory timing block
module dst_props
    import dst_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic I_SDRAM,
    input wire logic I_AREA2,
    input wire logic I_BUS_END,
    input wire logic O_BUS_GRANT,
    input wire logic O_REFRESH,
    input wire logic O_SELF_REFRESH,
    input wire logic [4:0] O_BUS_WIDTH
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // ============================================================
    // register bus
    a_wait_answer: assert property (I_CE && (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
        && $past(O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST) else $error("request not answered");
    a_wait_pulse: assert property (I_CE && !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    a_bit7_zero: assert property (
        !O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS == DST_ADDR_MTC |-> O_AVS_READDATA[7] == 1'h0)
        else $error("main register bit 7 reads one");
    // ============================================================
    // memory side
    a_area2_width: assert property (
        I_CE && I_AREA2 && !I_SDRAM |=> O_BUS_WIDTH == DST_A2_WIDTH) else $error("area-2 width not 16");
    a_self_quiet: assert property (
        O_SELF_REFRESH |-> !O_REFRESH && !O_BUS_GRANT) else $error("activity in self-refresh");
    a_ras_len: assert property (
        I_CE && $rose(O_REFRESH) |-> O_REFRESH [*2] ##[1:4] !O_REFRESH) else $error("refresh length out of range");
    a_gap_first: assert property (
        $fell(O_REFRESH) |-> !O_BUS_GRANT) else $error("grant without precharge gap");
    a_cycle_first: assert property (
        O_BUS_GRANT && !I_BUS_END |=> !O_REFRESH) else $error("refresh cut into bus cycle");
    a_grant_pulse: assert property (O_BUS_GRANT |=> !O_BUS_GRANT) else $error("grant longer than a cycle");
    // main scenarios reached
    c_refresh: cover property ($rose(O_REFRESH));
    c_self: cover property ($rose(O_SELF_REFRESH));
    c_late: cover property (O_BUS_GRANT ##[1:20] O_REFRESH);
endmodule : dst_props

bind dst_top dst_props u_props (.I_CLK, .I_RESET, .I_CE, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE,
    .O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_SDRAM, .I_AREA2, .I_BUS_END, .O_BUS_GRANT, .O_REFRESH,
    .O_SELF_REFRESH, .O_BUS_WIDTH);

// ---- verif/dst_mem_model.sv ----
// ============================================================
// external memory: ends each granted cycle after a set delay
module dst_mem_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_grant,
    input wire logic [3:0] i_delay,
    output logic o_end
);
    logic [3:0] left_q; // cycles still to run
    logic busy_q; // a cycle is in flight
    // slow memories get a long delay, so the end pulse may come late
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            busy_q <= 1'h0;
            left_q <= 4'h0;
            o_end <= 1'h0;
        end else begin
            o_end <= busy_q && left_q == 4'h0;
            busy_q <= i_grant || (busy_q && left_q != 4'h0);
            left_q <= i_grant ? i_delay : left_q - 4'h1;
        end
    end
endmodule : dst_mem_model

// ---- verif/testbench.sv ----
// ============================================================
// self-checking bench for the memory timing block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dst_pkg::*;
    typedef struct packed {
        logic sd; // sdram strap
        logic a2; // area-2 access
        logic [15:0] mtc; // main register value
        logic [15:0] a2c; // area-2 register value
        logic [14:0] res; // burst, edo, width, row bit, delay
    } dst_row_type;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1; // freeze input held at run
    logic [3:0] addr = 4'h0;
    logic rd = 1'h0, wr = 1'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] be = 4'hF;
    logic sd = 1'h0, a2 = 1'h0, ext = 1'h0, dma = 1'h0, req = 1'h0, bwr = 1'h0, cmp = 1'h0, sexit = 1'h0;
    logic [3:0] dly = 4'h3;
    logic [31:0] rdat;
    logic wreq, grant, rfr, slf, ack, burst, edo, bend;
    logic [3:0] rowb, row_to_column_delay;
    logic [4:0] width;
    int n_tests = 0;
    int n_mismatch = 0;
    int cycles = 0;
    int n, nw, nr, na, early;
    // area-2 register always written first, sdram rows keep edo at zero
    dst_row_type rows [10] = '{
        '{1'h0, 1'h0, 16'h0000, 16'h0000, {1'h0, 1'h0, 5'h00, 4'h9, 4'h1}},
        '{1'h0, 1'h0, 16'h1049, 16'h0000, {1'h1, 1'h1, 5'h00, 4'hA, 4'h2}},
        '{1'h0, 1'h0, 16'h2010, 16'h0000, {1'h0, 1'h0, 5'h00, 4'hB, 4'h3}},
        '{1'h0, 1'h0, 16'h3018, 16'h0000, {1'h0, 1'h0, 5'h00, 4'hC, 4'h4}},
        '{1'h1, 1'h0, 16'h3018, 16'h0000, {1'h1, 1'h0, 5'h00, 4'h9, 4'h4}},
        '{1'h1, 1'h0, 16'h0010, 16'h0000, {1'h1, 1'h0, 5'h00, 4'hB, 4'h1}},
        '{1'h1, 1'h0, 16'h0008, 16'h0000, {1'h1, 1'h0, 5'h00, 4'hA, 4'h1}},
        '{1'h0, 1'h1, 16'h0000, 16'h2058, {1'h1, 1'h0, 5'h10, 4'hC, 4'h3}},
        '{1'h1, 1'h1, 16'h1000, 16'h0000, {1'h1, 1'h0, 5'h00, 4'h9, 4'h2}},
        '{1'h0, 1'h1, 16'h0001, 16'h0001, {1'h0, 1'h0, 5'h10, 4'h9, 4'h1}}};

    dst_top dut (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq),
        .I_SDRAM(sd), .I_AREA2(a2), .I_EXTEND(ext), .I_DMA_SIDE(dma), .I_BUS_REQ(req), .I_BUS_WRITE(bwr),
        .I_BUS_END(bend), .I_CMP_MATCH(cmp), .I_SELF_EXIT(sexit), .O_BUS_GRANT(grant), .O_REFRESH(rfr),
        .O_SELF_REFRESH(slf), .O_REFRESH_ACK(ack), .O_BURST(burst), .O_ROW_BIT(rowb), .O_RCD(row_to_column_delay),
        .O_EDO_RISE(edo), .O_BUS_WIDTH(width));
    dst_mem_model u_mem (.i_clk(clk), .i_reset(rst), .i_grant(grant), .i_delay(dly), .o_end(bend));

    // ============================================================
    // clock and hang guard
    initial begin
        forever #10 clk = !clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    // ============================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdat <= {16'h0000, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'h0);
        q = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask : bus
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask : wreg
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'h0, a, 16'h0000, q);
        chk(q, exp, what);
    endtask : rchk
    task automatic wait_grant();
        while (grant !== 1'h1) begin
            @(posedge clk);
        end
    endtask : wait_grant
    // one timer match, then count refresh and ack cycles
    task automatic ras_len(output int nh, output int nk);
        @(posedge clk) cmp <= 1'h1;
        @(posedge clk) cmp <= 1'h0;
        nh = 0;
        nk = 0;
        repeat (40) begin
            @(posedge clk);
            nh += (rfr === 1'h1);
            nk += (ack === 1'h1);
        end
    endtask : ras_len
    // cycles between two back-to-back grants
    task automatic gap(input logic w, output int g);
        bwr <= w;
        req <= 1'h1;
        wait_grant();
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (grant !== 1'h1);
        req <= 1'h0;
        repeat (20) @(posedge clk);
    endtask : gap
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // ============================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rchk(DST_ADDR_MTC, 32'h0, "main reset");
        rchk(DST_ADDR_A2C, 32'h0, "area2 reset");
        foreach (rows[i]) begin
            wreg(DST_ADDR_A2C, rows[i].a2c);
            wreg(DST_ADDR_MTC, rows[i].mtc);
            sd <= rows[i].sd;
            a2 <= rows[i].a2;
            repeat (3) @(posedge clk);
            chk({burst, edo, width, rowb, row_to_column_delay}, rows[i].res, "decode");
        end
        // reserved bits, lanes, unmapped and read-only places
        sd <= 1'h0;
        a2 <= 1'h0;
        wreg(DST_ADDR_MTC, 16'hFFFF);
        rchk(DST_ADDR_MTC, 32'hFF5F, "main mask");
        wreg(DST_ADDR_A2C, 16'hFFFF);
        rchk(DST_ADDR_A2C, 32'hF35E, "area2 mask");
        wreg(DST_ADDR_A2C, 16'h0000);
        wreg(DST_ADDR_MTC, 16'h0000);
        be <= 4'h2;
        wreg(DST_ADDR_MTC, 16'hFFFF);
        be <= 4'hF;
        rchk(DST_ADDR_MTC, 32'hFF00, "upper lane");
        wreg(4'hC, 16'hFFFF);
        rchk(4'hC, 32'h0, "unmapped");
        wreg(DST_ADDR_MTC, 16'h0000);
        wreg(DST_ADDR_STS, 16'hFFFF);
        rchk(DST_ADDR_STS, 32'h0, "status");
        // refresh length for every assert-time code
        for (int c = 0; c < 4; c++) begin
            wreg(DST_ADDR_MTC, 16'h0004 | (16'(c) << 8));
            ras_len(n, na);
            chk(32'(n), 32'(c + 2), "refresh cycles");
            chk(32'(na), 32'h1, "refresh ack");
        end
        wreg(DST_ADDR_MTC, 16'h0300);
        ras_len(n, na);
        chk(32'(n), 32'h0, "refresh off");
        // write-to-precharge gap on sdram, none on dram, precharge step
        sd <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            wreg(DST_ADDR_MTC, 16'(c) << 10);
            gap(1'h1, nw);
            gap(1'h0, nr);
            chk(32'(nw - nr), 32'((c == 3) ? 3 : c + 1), "write gap");
        end
        sd <= 1'h0;
        wreg(DST_ADDR_MTC, 16'h0800);
        gap(1'h1, nw);
        gap(1'h0, nr);
        chk(32'(nw - nr), 32'h0, "dram write gap");
        wreg(DST_ADDR_MTC, 16'h4000);
        gap(1'h0, nw);
        chk(32'(nw - nr), 32'h1, "precharge step");
        // match during a slow bus cycle waits for its end
        wreg(DST_ADDR_MTC, 16'h0004);
        dly <= 4'h8;
        req <= 1'h1;
        wait_grant();
        req <= 1'h0;
        ras_len(n, na);
        chk(32'(n), 32'h2, "late refresh");
        chk(32'(na), 32'h1, "late ack");
        req <= 1'h1;
        wait_grant();
        req <= 1'h0;
        @(posedge clk) cmp <= 1'h1;
        @(posedge clk) cmp <= 1'h0;
        early = 0;
        while (bend !== 1'h1) begin
            @(posedge clk);
            early += (rfr === 1'h1) ? 100 : 1;
        end
        chk(32'(early >= 100), 32'h0, "refresh inside cycle");
        repeat (20) @(posedge clk);
        // self-refresh waits for the cycle, then ignores matches
        req <= 1'h1;
        wait_grant();
        req <= 1'h0;
        wreg(DST_ADDR_MTC, 16'h0006);
        chk(32'(slf), 32'h0, "self early");
        repeat (12) @(posedge clk);
        chk(32'(slf), 32'h1, "self entered");
        rchk(DST_ADDR_STS, {26'h0, 3'h2, DST_SELF}, "status self");
        ras_len(n, na);
        chk(32'(n), 32'h0, "self ignores");
        sexit <= 1'h1;
        // mode bits still set, so the sequencer re-enters two cycles after leaving
        repeat (2) @(posedge clk);
        chk(32'(slf), 32'h0, "self exit");
        wreg(DST_ADDR_MTC, 16'h3000);
        sexit <= 1'h0;
        // extended timing on the dma side and the cpu side
        ext <= 1'h1;
        dma <= 1'h1;
        repeat (3) @(posedge clk);
        chk(32'(row_to_column_delay), 32'h1, "dma extended");
        dma <= 1'h0;
        repeat (3) @(posedge clk);
        chk(32'(row_to_column_delay), 32'h4, "cpu extended");
        // second reset mid-run
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rchk(DST_ADDR_MTC, 32'h0, "main re-reset");
        conclude();
    end
endmodule : testbench
